// [core/pin_irq_pkg.sv]
/*
  Constants and carrier types for the port edge interrupt and wired-or block.
  Assumes a 32-bit APB master on pclk; register offsets are byte addresses.
*/
package pin_irq_pkg;

  // ==========================================================================
  // Bus geometry
  // ==========================================================================
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;

  // ==========================================================================
  // Register offsets
  // ==========================================================================
  localparam logic [11:0] RESERVED_OFF = 12'h000;
  localparam logic [11:0] PORT_R_OD_OFF = 12'h004;
  localparam logic [11:0] PORT_R_DIR_OFF = 12'h008;
  localparam logic [11:0] PORT_R_DATA_OFF = 12'h00c;
  localparam logic [11:0] PORT_T_POL_OFF = 12'h010;
  localparam logic [11:0] PORT_S_POL_OFF = 12'h014;
  localparam logic [11:0] PORT_T_IEN_OFF = 12'h018;
  localparam logic [11:0] PORT_T_FLG_OFF = 12'h01c;
  localparam logic [11:0] PORT_S_IEN_OFF = 12'h020;
  localparam logic [11:0] PORT_S_FLG_OFF = 12'h024;
  localparam logic [11:0] PORT_AD_IEN_OFF = 12'h028;
  localparam logic [11:0] PORT_AD_FLG_OFF = 12'h02c;
  localparam logic [11:0] PIN_STATE_OFF = 12'h030;

  // ==========================================================================
  // Reset values and implemented bit masks
  // ==========================================================================
  localparam logic [7:0] OD_RESET = 8'h00;
  localparam logic [7:0] DIR_RESET = 8'h00;
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic [7:0] POL_RESET = 8'h00;
  localparam logic [7:0] IEN_RESET = 8'h00;
  localparam logic [7:0] FLG_RESET = 8'h00;
  localparam logic [7:0] T_FLAG_MASK = 8'h60;
  localparam logic [7:0] S_PIN_MASK = 8'h6c;
  localparam logic [7:0] AD_FLAG_MASK = 8'hff;
  localparam logic [7:0] T_IEN_MASK = 8'hff;

  // ==========================================================================
  // Timing
  // ==========================================================================
  // Cycles after reset before the synchronised pins are trusted for edges
  localparam logic [1:0] SYNC_SETTLE = 2'd3;

  // ==========================================================================
  // Carrier: one byte per edge-capable port
  // ==========================================================================
  typedef struct packed {
    logic [7:0] ad;
    logic [7:0] s;
    logic [7:0] t;
  } edge_pins_t;

endpackage

// [core/port_pin_edge_interrupts.sv]
/*
  Edge interrupt flags for ports T, S and AD, wired-or output control for
  port R, and the APB register file that reaches them.
  Assumes an APB master on pclk, pins that are asynchronous to pclk, and an
  external pad that resolves the port R wire from port_r_pin_out and _oe.
*/
// What this block does
// - A set port R open-drain bit makes that output only pull low, a clear one drives both levels.
// - The open-drain bits change nothing on a port R pin that is an input.
// - The reserved word reads as zero and ignores writes.
// - Port T has eight read-write enable bits; only six and five gate an edge interrupt.
// - Port T flags six and five are set by the edge that the port T polarity bit selects.
// - Writing one clears an edge flag and writing zero leaves it alone.
// - A pin requests an interrupt while its flag and its enable are both set.
// - Port S enable bits exist only at six, five, three and two.
// - Port S flags six, five, three and two are set by the edge their polarity bit selects.
// - Port AD has eight read-write enable bits, each gating its pin's edge interrupt.
// - Each port AD flag is set by a falling edge on its pin.
// - Writing one clears a port AD flag and writing zero alters none.
// - Polarity one selects a rising edge and zero a falling edge.
module port_pin_edge_interrupts (
  // Clock, reset and freeze
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Port R pad
  input wire logic [7:0] port_r_pin_in,
  output logic [7:0] port_r_pin_out,
  output logic [7:0] port_r_pin_oe,
  // Edge capable pins
  input wire pin_irq_pkg::edge_pins_t edge_pin_in,
  // Interrupt
  output logic irq
);

  // ==========================================================================
  // State
  // ==========================================================================
  logic [31:0] prdata_reg, prdata_next;
  logic pready_reg, pready_next;
  logic pslverr_reg, pslverr_next;
  logic [7:0] port_r_open_drain_select_reg, port_r_open_drain_select_next;
  logic [7:0] port_r_dir_reg, port_r_dir_next;
  logic [7:0] port_r_data_reg, port_r_data_next;
  logic [7:0] port_t_polarity_select_reg, port_t_polarity_select_next;
  logic [7:0] port_s_polarity_select_reg, port_s_polarity_select_next;
  pin_irq_pkg::edge_pins_t irq_enable_reg, irq_enable_next;
  pin_irq_pkg::edge_pins_t edge_flags_reg, edge_flags_next;
  logic irq_reg, irq_next;

  logic [31:0] pin_meta_reg;
  logic [31:0] pin_sync_reg;
  logic [31:0] pin_prev_reg;
  logic [1:0] settle_reg, settle_next;
  logic [7:0] port_r_pin_out_reg, port_r_pin_out_next;
  logic [7:0] port_r_pin_oe_reg, port_r_pin_oe_next;

  // ==========================================================================
  // Edge detection
  // ==========================================================================
  logic [23:0] edge_now;
  logic [23:0] edge_old;
  logic [23:0] polarity;
  logic [23:0] flag_mask;
  logic [23:0] edge_set;
  logic settled;

  assign edge_now = pin_sync_reg[23:0];
  assign edge_old = pin_prev_reg[23:0];
  // Port AD has no polarity control and is always falling-edge
  assign polarity = {8'h00, port_s_polarity_select_reg, port_t_polarity_select_reg};
  assign flag_mask = {pin_irq_pkg::AD_FLAG_MASK, pin_irq_pkg::S_PIN_MASK,
                      pin_irq_pkg::T_FLAG_MASK};
  // Reset leaves the sync chain at zero; a pin already high would look
  // like a rising edge, so edges are ignored until the chain has settled.
  assign settled = (settle_reg == pin_irq_pkg::SYNC_SETTLE);

  genvar i;
  generate
    for (i = 0; i < 24; i = i + 1)
    begin : g_edge
      assign edge_set[i] = settled && flag_mask[i] &&
                           (polarity[i] ? (edge_now[i] && !edge_old[i])
                                        : (!edge_now[i] && edge_old[i]));
    end
  endgenerate

  // ==========================================================================
  // Bus decode and register updates
  // ==========================================================================
  logic access;
  logic wr_fire;
  logic [23:0] flag_clear;
  logic [31:0] rd_data;
  logic rd_err;

  // Zero-wait answers would need a combinational pready, so each access
  // phase spends one cycle preparing a registered answer.
  assign access = psel && penable;
  assign wr_fire = access && pready_reg && pwrite;

  always_comb
  begin
    rd_data = 32'h0000_0000;
    rd_err = 1'b0;
    if (paddr == pin_irq_pkg::RESERVED_OFF)
    begin
      rd_data = 32'h0000_0000;
    end
    else if (paddr == pin_irq_pkg::PORT_R_OD_OFF)
    begin
      rd_data = {24'h000000, port_r_open_drain_select_reg};
    end
    else if (paddr == pin_irq_pkg::PORT_R_DIR_OFF)
    begin
      rd_data = {24'h000000, port_r_dir_reg};
    end
    else if (paddr == pin_irq_pkg::PORT_R_DATA_OFF)
    begin
      rd_data = {24'h000000, port_r_data_reg};
    end
    else if (paddr == pin_irq_pkg::PORT_T_POL_OFF)
    begin
      rd_data = {24'h000000, port_t_polarity_select_reg};
    end
    else if (paddr == pin_irq_pkg::PORT_S_POL_OFF)
    begin
      rd_data = {24'h000000, port_s_polarity_select_reg};
    end
    else if (paddr == pin_irq_pkg::PORT_T_IEN_OFF)
    begin
      rd_data = {24'h000000, irq_enable_reg.t};
    end
    else if (paddr == pin_irq_pkg::PORT_T_FLG_OFF)
    begin
      rd_data = {24'h000000, edge_flags_reg.t};
    end
    else if (paddr == pin_irq_pkg::PORT_S_IEN_OFF)
    begin
      rd_data = {24'h000000, irq_enable_reg.s};
    end
    else if (paddr == pin_irq_pkg::PORT_S_FLG_OFF)
    begin
      rd_data = {24'h000000, edge_flags_reg.s};
    end
    else if (paddr == pin_irq_pkg::PORT_AD_IEN_OFF)
    begin
      rd_data = {24'h000000, irq_enable_reg.ad};
    end
    else if (paddr == pin_irq_pkg::PORT_AD_FLG_OFF)
    begin
      rd_data = {24'h000000, edge_flags_reg.ad};
    end
    else if (paddr == pin_irq_pkg::PIN_STATE_OFF)
    begin
      rd_data = pin_sync_reg;
    end
    else
    begin
      rd_err = 1'b1;
    end
  end

  always_comb
  begin
    prdata_next = prdata_reg;
    pready_next = 1'b0;
    pslverr_next = 1'b0;
    port_r_open_drain_select_next = port_r_open_drain_select_reg;
    port_r_dir_next = port_r_dir_reg;
    port_r_data_next = port_r_data_reg;
    port_t_polarity_select_next = port_t_polarity_select_reg;
    port_s_polarity_select_next = port_s_polarity_select_reg;
    irq_enable_next = irq_enable_reg;
    flag_clear = 24'h000000;
    if (access && !pready_reg)
    begin
      pready_next = 1'b1;
      pslverr_next = rd_err;
      prdata_next = pwrite ? 32'h0000_0000 : rd_data;
    end
    if (wr_fire)
    begin
      // reserved and unmapped writes fall through unused
      if (paddr == pin_irq_pkg::PORT_R_OD_OFF)
      begin
        port_r_open_drain_select_next = pwdata[7:0];
      end
      else if (paddr == pin_irq_pkg::PORT_R_DIR_OFF)
      begin
        port_r_dir_next = pwdata[7:0];
      end
      else if (paddr == pin_irq_pkg::PORT_R_DATA_OFF)
      begin
        port_r_data_next = pwdata[7:0];
      end
      else if (paddr == pin_irq_pkg::PORT_T_POL_OFF)
      begin
        port_t_polarity_select_next = pwdata[7:0];
      end
      else if (paddr == pin_irq_pkg::PORT_S_POL_OFF)
      begin
        port_s_polarity_select_next = pwdata[7:0];
      end
      else if (paddr == pin_irq_pkg::PORT_T_IEN_OFF)
      begin
        irq_enable_next.t = pwdata[7:0] & pin_irq_pkg::T_IEN_MASK;
      end
      else if (paddr == pin_irq_pkg::PORT_T_FLG_OFF)
      begin
        flag_clear[7:0] = pwdata[7:0];
      end
      else if (paddr == pin_irq_pkg::PORT_S_IEN_OFF)
      begin
        irq_enable_next.s = pwdata[7:0] & pin_irq_pkg::S_PIN_MASK;
      end
      else if (paddr == pin_irq_pkg::PORT_S_FLG_OFF)
      begin
        flag_clear[15:8] = pwdata[7:0];
      end
      else if (paddr == pin_irq_pkg::PORT_AD_IEN_OFF)
      begin
        irq_enable_next.ad = pwdata[7:0];
      end
      else if (paddr == pin_irq_pkg::PORT_AD_FLG_OFF)
      begin
        flag_clear[23:16] = pwdata[7:0];
      end
    end
    edge_flags_next = (edge_flags_reg & ~flag_clear) | edge_set;
    irq_next = |(edge_flags_next & irq_enable_next);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_reg <= 32'h0000_0000;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      port_r_open_drain_select_reg <= pin_irq_pkg::OD_RESET;
      port_r_dir_reg <= pin_irq_pkg::DIR_RESET;
      port_r_data_reg <= pin_irq_pkg::DATA_RESET;
      port_t_polarity_select_reg <= pin_irq_pkg::POL_RESET;
      port_s_polarity_select_reg <= pin_irq_pkg::POL_RESET;
      irq_enable_reg <= {3{pin_irq_pkg::IEN_RESET}};
      edge_flags_reg <= {3{pin_irq_pkg::FLG_RESET}};
      irq_reg <= 1'b0;
    end
    else if (ce)
    begin
      prdata_reg <= prdata_next;
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
      port_r_open_drain_select_reg <= port_r_open_drain_select_next;
      port_r_dir_reg <= port_r_dir_next;
      port_r_data_reg <= port_r_data_next;
      port_t_polarity_select_reg <= port_t_polarity_select_next;
      port_s_polarity_select_reg <= port_s_polarity_select_next;
      irq_enable_reg <= irq_enable_next;
      edge_flags_reg <= edge_flags_next;
      irq_reg <= irq_next;
    end
  end

  // ==========================================================================
  // Pin synchronisers and port R drivers
  // ==========================================================================
  always_comb
  begin
    settle_next = settle_reg;
    if (!settled)
    begin
      settle_next = settle_reg + 2'd1;
    end
    port_r_pin_out_next = port_r_data_reg & ~port_r_open_drain_select_reg;
    port_r_pin_oe_next = port_r_dir_reg &
                         (~port_r_open_drain_select_reg | ~port_r_data_reg);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_meta_reg <= 32'h0000_0000;
      pin_sync_reg <= 32'h0000_0000;
      pin_prev_reg <= 32'h0000_0000;
      settle_reg <= 2'd0;
      port_r_pin_out_reg <= 8'h00;
      port_r_pin_oe_reg <= 8'h00;
    end
    else if (ce)
    begin
      pin_meta_reg <= {port_r_pin_in, edge_pin_in};
      pin_sync_reg <= pin_meta_reg;
      pin_prev_reg <= pin_sync_reg;
      settle_reg <= settle_next;
      port_r_pin_out_reg <= port_r_pin_out_next;
      port_r_pin_oe_reg <= port_r_pin_oe_next;
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign port_r_pin_out = port_r_pin_out_reg;
  assign port_r_pin_oe = port_r_pin_oe_reg;
  assign irq = irq_reg;

endmodule // port_pin_edge_interrupts

// [testbench/pin_irq_chk.sv]
/*
  Checker for the port edge interrupt block: APB answer, port R drive, irq.
  Assumes it sees only the top ports; bound to every design instance.
*/
module pin_irq_chk (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Pins and interrupt
  input wire logic [7:0] port_r_pin_in,
  input wire logic [7:0] port_r_pin_out,
  input wire logic [7:0] port_r_pin_oe,
  input wire pin_irq_pkg::edge_pins_t edge_pin_in,
  input wire logic irq
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================================
  // Shadows of the registers the assertions need
  // ==========================================================================
  logic wr;
  logic [7:0] od_reg, dir_reg;
  logic [23:0] en_reg;
  assign wr = ce && psel && penable && pready && pwrite;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      od_reg <= 8'h00;
      dir_reg <= 8'h00;
      en_reg <= 24'h0;
    end
    else if (wr)
    begin
      if (paddr == pin_irq_pkg::PORT_R_OD_OFF) od_reg <= pwdata[7:0];
      if (paddr == pin_irq_pkg::PORT_R_DIR_OFF) dir_reg <= pwdata[7:0];
      if (paddr == pin_irq_pkg::PORT_T_IEN_OFF) en_reg[7:0] <= pwdata[7:0];
      if (paddr == pin_irq_pkg::PORT_S_IEN_OFF) en_reg[15:8] <= pwdata[7:0] & 8'h6c;
      if (paddr == pin_irq_pkg::PORT_AD_IEN_OFF) en_reg[23:16] <= pwdata[7:0];
    end
  // ==========================================================================
  // Assertions
  // ==========================================================================
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  pready_pulse_a: assert property (pready |=> !pready)
    else $error("pready held longer than one cycle");
  ready_timing_a: assert property ((ce && psel && penable && !pready) |=> pready)
    else $error("no answer one cycle after access");
  reserved_read_a: assert property ((pready && !pwrite && paddr == 12'h000)
    |-> (prdata == 32'h0 && !pslverr))
    else $error("reserved word not read as zero");
  slverr_map_a: assert property ((pready && paddr[1:0] == 2'b00)
    |-> (pslverr == (paddr > pin_irq_pkg::PIN_STATE_OFF)))
    else $error("error response wrong for address");
  od_low_only_a: assert property ((od_reg & $past(od_reg) & port_r_pin_oe & port_r_pin_out)
    == 8'h00)
    else $error("open drain bit drives high");
  input_no_drive_a: assert property ((~dir_reg & ~$past(dir_reg) & port_r_pin_oe) == 8'h00)
    else $error("input pin is driven");
  mask_gates_a: assert property (irq |-> (en_reg != 24'h0 || $past(en_reg) != 24'h0))
    else $error("irq with every enable clear");
  reset_quiet_a: assert property ($rose(presetn) |-> (!irq) [*3])
    else $error("irq during sync settle");
  ad_fall_irq_a: assert property ((($past(edge_pin_in.ad) & ~edge_pin_in.ad & en_reg[23:16])
    != 8'h00) |-> ##[1:8] irq)
    else $error("enabled falling edge gave no irq");
endmodule // pin_irq_chk

bind port_pin_edge_interrupts pin_irq_chk i_pin_irq_chk (.pclk(pclk), .presetn(presetn),
  .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .port_r_pin_in(port_r_pin_in),
  .port_r_pin_out(port_r_pin_out), .port_r_pin_oe(port_r_pin_oe),
  .edge_pin_in(edge_pin_in), .irq(irq));

// [testbench/pin_partner.sv]
/*
  Model of the pads and outside world: edge pins and the port R wire.
  Assumes the bench sets the wanted pin levels; port R carries a pull-up.
*/
module pin_partner (
  // Clock
  input wire logic pclk,
  // Levels asked for by the bench
  input wire pin_irq_pkg::edge_pins_t pins_want,
  // Port R pad
  input wire logic [7:0] port_r_pin_out,
  input wire logic [7:0] port_r_pin_oe,
  output logic [7:0] port_r_pin_in,
  // Edge pins
  output pin_irq_pkg::edge_pins_t edge_pin_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // wakeup paths open
  // Frontplane off and converter inputs on, so every level reaches the block
  always @(posedge pclk) edge_pin_in <= pins_want;
  // wired-or wire
  // Undriven bits float up through the pull-up, so an open-drain one still reads back as one
  assign port_r_pin_in = ~port_r_pin_oe | port_r_pin_out;
endmodule // pin_partner

// [testbench/port_pin_edge_interrupts_tb.sv]
/*
  Self-checking bench for the port edge interrupt block.
  Assumes pin_partner on the pins and pin_irq_chk bound to the design.
*/
module port_pin_edge_interrupts_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================================
  // Signals
  // ==========================================================================
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic ce = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, irq;
  logic [7:0] port_r_pin_in, port_r_pin_out, port_r_pin_oe;
  pin_irq_pkg::edge_pins_t edge_pin_in;
  pin_irq_pkg::edge_pins_t pins_want = '0;
  int n_fail = 0;
  int n_compared = 0;
  always #20 pclk = ~pclk;
  port_pin_edge_interrupts i_port_pin_edge_interrupts (.pclk(pclk), .presetn(presetn),
    .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .port_r_pin_in(port_r_pin_in), .port_r_pin_out(port_r_pin_out),
    .port_r_pin_oe(port_r_pin_oe), .edge_pin_in(edge_pin_in), .irq(irq));
  pin_partner i_pin_partner (.pclk(pclk), .pins_want(pins_want),
    .port_r_pin_out(port_r_pin_out), .port_r_pin_oe(port_r_pin_oe),
    .port_r_pin_in(port_r_pin_in), .edge_pin_in(edge_pin_in));
  // ==========================================================================
  // Shared tasks
  // ==========================================================================
  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // No wait is open-ended: a missing answer ends the run
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d,
    output logic [31:0] q, output logic e);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1)
    begin
      n_fail++;
      close_out();
    end
    else
    begin
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(a, 1'b1, d, q, e);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] q;
    logic e;
    apb(a, 1'b0, 32'h0, q, e);
    check(q, exp);
    check({31'h0, e}, 32'h0);
  endtask
  // ==========================================================================
  // Scenarios
  // ==========================================================================
  task automatic t_regs();
    logic [31:0] q;
    logic e;
    wr(12'h000, 32'h0000_00ff);
    rd(12'h000, 32'h0);
    apb(12'h040, 1'b0, 32'h0, q, e);
    check({31'h0, e}, 32'h1);
    for (int i = 1; i < 12; i++)
      rd(12'(4 * i), 32'h0);
    $display("t_regs done");
  endtask
  task automatic t_enables();
    wr(pin_irq_pkg::PORT_T_IEN_OFF, 32'hff);
    wr(pin_irq_pkg::PORT_S_IEN_OFF, 32'hff);
    wr(pin_irq_pkg::PORT_AD_IEN_OFF, 32'hff);
    rd(pin_irq_pkg::PORT_T_IEN_OFF, 32'hff);
    rd(pin_irq_pkg::PORT_S_IEN_OFF, 32'h6c);
    rd(pin_irq_pkg::PORT_AD_IEN_OFF, 32'hff);
    $display("t_enables done");
  endtask
  // Falling polarity first, then rising; AD only ever reacts to the fall
  task automatic t_edges();
    logic [7:0] p;
    for (int k = 0; k < 2; k++)
    begin
      p = k ? 8'h00 : 8'hff;
      wr(pin_irq_pkg::PORT_T_POL_OFF, {24'h0, ~p});
      wr(pin_irq_pkg::PORT_S_POL_OFF, {24'h0, ~p});
      pins_want <= {3{p}};
      repeat (8) @(posedge pclk);
      wr(pin_irq_pkg::PORT_T_FLG_OFF, 32'hff);
      wr(pin_irq_pkg::PORT_S_FLG_OFF, 32'hff);
      wr(pin_irq_pkg::PORT_AD_FLG_OFF, 32'hff);
      pins_want <= {3{~p}};
      repeat (8) @(posedge pclk);
      rd(pin_irq_pkg::PORT_T_FLG_OFF, 32'h60);
      rd(pin_irq_pkg::PORT_S_FLG_OFF, 32'h6c);
      rd(pin_irq_pkg::PORT_AD_FLG_OFF, {24'h0, p});
    end
    $display("t_edges done");
  endtask
  task automatic t_w1c();
    pins_want <= 24'h0;
    repeat (8) @(posedge pclk);
    wr(pin_irq_pkg::PORT_AD_FLG_OFF, 32'h0);
    rd(pin_irq_pkg::PORT_AD_FLG_OFF, 32'hff);
    wr(pin_irq_pkg::PORT_T_IEN_OFF, 32'h0);
    wr(pin_irq_pkg::PORT_S_IEN_OFF, 32'h0);
    wr(pin_irq_pkg::PORT_AD_IEN_OFF, 32'h0);
    repeat (2) @(posedge pclk);
    check({31'h0, irq}, 32'h0);
    wr(pin_irq_pkg::PORT_AD_IEN_OFF, 32'h08);
    repeat (2) @(posedge pclk);
    check({31'h0, irq}, 32'h1);
    wr(pin_irq_pkg::PORT_AD_FLG_OFF, 32'h08);
    repeat (2) @(posedge pclk);
    check({31'h0, irq}, 32'h0);
    rd(pin_irq_pkg::PORT_AD_FLG_OFF, 32'hf7);
    wr(pin_irq_pkg::PORT_T_FLG_OFF, 32'h20);
    rd(pin_irq_pkg::PORT_T_FLG_OFF, 32'h40);
    wr(pin_irq_pkg::PORT_S_FLG_OFF, 32'h24);
    rd(pin_irq_pkg::PORT_S_FLG_OFF, 32'h48);
    pins_want <= 24'hffffff;
    repeat (8) @(posedge pclk);
    rd(pin_irq_pkg::PORT_T_FLG_OFF, 32'h60);
    check({31'h0, irq}, 32'h0);
    $display("t_w1c done");
  endtask
  task automatic t_port_r();
    wr(pin_irq_pkg::PORT_R_DIR_OFF, 32'hff);
    wr(pin_irq_pkg::PORT_R_DATA_OFF, 32'h5a);
    repeat (2) @(posedge pclk);
    check({16'h0, port_r_pin_oe, port_r_pin_out}, 32'hff5a);
    wr(pin_irq_pkg::PORT_R_OD_OFF, 32'h0f);
    repeat (2) @(posedge pclk);
    check({16'h0, port_r_pin_oe, port_r_pin_out}, 32'hf550);
    rd(pin_irq_pkg::PIN_STATE_OFF, 32'h5aff_ffff);
    wr(pin_irq_pkg::PORT_R_DIR_OFF, 32'h0);
    repeat (2) @(posedge pclk);
    check({24'h0, port_r_pin_oe}, 32'h0);
    $display("t_port_r done");
  endtask
  // A fall seen while ce is low must wait until ce returns
  task automatic t_freeze();
    ce <= 1'b0;
    pins_want <= 24'h00ffff;
    repeat (5) @(posedge pclk);
    check({31'h0, irq}, 32'h0);
    ce <= 1'b1;
    repeat (6) @(posedge pclk);
    check({31'h0, irq}, 32'h1);
    $display("t_freeze done");
  endtask
  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial
  begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    t_regs();
    t_enables();
    t_edges();
    t_w1c();
    t_port_r();
    t_freeze();
    close_out();
  end
endmodule // port_pin_edge_interrupts_tb
